//--- rtl/sisf_top.sv
// Contract
// - operating mode change sets status bit 7
// - two missing main reference cycles set bit 6
// - no reference failure in free-run or holdover
// - channel 14..9 validity change latches bits 5..0
// - writing one clears a latched status bit
// - status byte resets to 0x3F
// - readback is read-only, frequency bits 18:16 low
// - select 0 main path, 1 auxiliary path
module sisf_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                                i_clock,
    input  wire logic                                i_rst_b,
    // register bus
    input  wire sisf_pkg::sisf_axi_req_t             i_axi,
    output sisf_pkg::sisf_axi_rsp_t                  o_axi,
    // timing core status
    input  wire logic [sisf_pkg::OPMODE_W-1:0]       i_op_mode,
    input  wire logic                                i_freerun_holdover,
    input  wire logic                                i_ref_cycle_tick,
    input  wire logic                                i_ref_cycle_seen,
    input  wire logic [sisf_pkg::CHAN_N-1:0]         i_chan_valid,
    input  wire logic [sisf_pkg::FREQ_W-1:0]         i_main_dpll_path_freq,
    input  wire logic [sisf_pkg::FREQ_W-1:0]         i_auxiliary_dpll_path_freq,
    // interrupt
    output logic                                     o_irq
);

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [7:0] addr);
        word_index = {2'h0, addr[7:2]};
    endfunction : word_index

    function automatic logic is_mapped(input logic [7:0] addr);
        logic [7:0] idx;
        idx       = word_index(addr);
        is_mapped = (addr[1:0] == 2'h0) &&
                    ((idx == sisf_pkg::IDX_IRQ_STATUS_MID_BYTE) ||
                     (idx == sisf_pkg::IDX_PLL_FREQ_READBACK_TOP) ||
                     (idx == sisf_pkg::IDX_SRC_CFG) ||
                     (idx == sisf_pkg::IDX_IRQ_MASK) ||
                     (idx == sisf_pkg::IDX_IRQ_PEND));
    endfunction : is_mapped

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    sisf_pkg::sisf_state_t                st_q;
    sisf_pkg::sisf_state_t                st_d;
    logic [sisf_pkg::STAT_W-1:0]          status;
    logic [sisf_pkg::STAT_W-1:0]          pend;
    logic [sisf_pkg::STAT_W-1:0]          evt;
    logic [sisf_pkg::STAT_W-1:0]          status_clr;
    logic [sisf_pkg::STAT_W-1:0]          pend_clr;
    logic                                 ref_fail;
    logic                                 wr_fire;
    logic                                 rd_fire;
    logic [7:0]                           wr_idx;
    logic [7:0]                           rd_idx;
    logic                                 wr_lane0;
    logic [sisf_pkg::FREQ_TOP_W-1:0]      freq_sel;

    // -------------------------------------------------------------------
    // bus handshakes
    // -------------------------------------------------------------------
    assign wr_fire  = i_axi.awvalid && i_axi.wvalid && !st_q.bvalid;
    assign rd_fire  = i_axi.arvalid && !st_q.rvalid;
    assign wr_idx   = word_index(i_axi.awaddr);
    assign rd_idx   = word_index(i_axi.araddr);
    assign wr_lane0 = wr_fire && is_mapped(i_axi.awaddr) && i_axi.wstrb[0];

    always_comb
    begin
        o_axi         = '0;
        o_axi.awready = wr_fire;
        o_axi.wready  = wr_fire;
        o_axi.bvalid  = st_q.bvalid;
        o_axi.bresp   = st_q.bresp;
        o_axi.arready = !st_q.rvalid;
        o_axi.rvalid  = st_q.rvalid;
        o_axi.rdata   = st_q.rdata;
        o_axi.rresp   = st_q.rresp;
    end

    // -------------------------------------------------------------------
    // events
    // -------------------------------------------------------------------
    sisf_miss_detect u_miss (
        .i_clock            (i_clock),
        .i_rst_b            (i_rst_b),
        .i_cycle_tick       (i_ref_cycle_tick),
        .i_cycle_seen       (i_ref_cycle_seen),
        .i_freerun_holdover (i_freerun_holdover),
        .o_fail             (ref_fail)
    );

    always_comb
    begin
        evt                             = '0;
        evt[sisf_pkg::BIT_MODE_CHG]     = st_q.primed && (i_op_mode != st_q.mode_prev);
        evt[sisf_pkg::BIT_REF_FAIL]     = ref_fail && !i_freerun_holdover;
        evt[sisf_pkg::CHAN_N-1:0]       = st_q.primed ? (i_chan_valid ^ st_q.chan_prev)
                                                      : '0;
    end

    // write one clears, write zero leaves the bit alone
    assign status_clr = (wr_lane0 && (wr_idx == sisf_pkg::IDX_IRQ_STATUS_MID_BYTE)) ?
                        i_axi.wdata[sisf_pkg::STAT_W-1:0] : '0;
    // the pending copy is cleared by reading it
    assign pend_clr   = (rd_fire && is_mapped(i_axi.araddr) && (rd_idx == sisf_pkg::IDX_IRQ_PEND)) ?
                        '1 : '0;

    sisf_flag_bank #(
        .RST_VAL (sisf_pkg::STATUS_RST)
    ) u_status (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_set   (evt),
        .i_clr   (status_clr),
        .o_flags (status)
    );

    sisf_flag_bank #(
        .RST_VAL (sisf_pkg::PEND_RST)
    ) u_pend (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_set   (evt),
        .i_clr   (pend_clr),
        .o_flags (pend)
    );

    // -------------------------------------------------------------------
    // frequency readback path
    // -------------------------------------------------------------------
    assign freq_sel = st_q.src_sel ?
        i_auxiliary_dpll_path_freq[sisf_pkg::FREQ_TOP_LSB +: sisf_pkg::FREQ_TOP_W] :
        i_main_dpll_path_freq[sisf_pkg::FREQ_TOP_LSB +: sisf_pkg::FREQ_TOP_W];

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb
    begin
        st_d           = st_q;
        st_d.primed    = 1'b1;
        st_d.mode_prev = i_op_mode;
        st_d.chan_prev = i_chan_valid;
        st_d.freq_top  = freq_sel;
        st_d.irq       = |(pend & st_q.mask);

        if (st_q.bvalid && i_axi.bready)
        begin
            st_d.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            st_d.bvalid = 1'b1;
            st_d.bresp  = is_mapped(i_axi.awaddr) ? sisf_pkg::RESP_OKAY : sisf_pkg::RESP_SLVERR;
        end
        if (wr_lane0 && (wr_idx == sisf_pkg::IDX_SRC_CFG))
        begin
            st_d.src_sel = i_axi.wdata[sisf_pkg::SEL_BIT];
        end
        if (wr_lane0 && (wr_idx == sisf_pkg::IDX_IRQ_MASK))
        begin
            st_d.mask = i_axi.wdata[sisf_pkg::STAT_W-1:0];
        end

        if (st_q.rvalid && i_axi.rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (rd_fire)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = is_mapped(i_axi.araddr) ? sisf_pkg::RESP_OKAY : sisf_pkg::RESP_SLVERR;
            st_d.rdata  = '0;
            if (is_mapped(i_axi.araddr))
            begin
                case (rd_idx)
                    sisf_pkg::IDX_IRQ_STATUS_MID_BYTE:
                        st_d.rdata[sisf_pkg::STAT_W-1:0] = status;
                    sisf_pkg::IDX_PLL_FREQ_READBACK_TOP:
                        st_d.rdata[sisf_pkg::FREQ_TOP_W-1:0] = st_q.freq_top;
                    sisf_pkg::IDX_SRC_CFG:
                        st_d.rdata[sisf_pkg::SEL_BIT] = st_q.src_sel;
                    sisf_pkg::IDX_IRQ_MASK:
                        st_d.rdata[sisf_pkg::STAT_W-1:0] = st_q.mask;
                    sisf_pkg::IDX_IRQ_PEND:
                        st_d.rdata[sisf_pkg::STAT_W-1:0] = pend;
                    default:
                        st_d.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_q.bvalid    <= 1'b0;
            st_q.bresp     <= sisf_pkg::RESP_OKAY;
            st_q.rvalid    <= 1'b0;
            st_q.rresp     <= sisf_pkg::RESP_OKAY;
            st_q.rdata     <= '0;
            st_q.src_sel   <= sisf_pkg::SRC_SEL_RST;
            st_q.mask      <= sisf_pkg::MASK_RST;
            st_q.freq_top  <= sisf_pkg::FREQ_TOP_RST[sisf_pkg::FREQ_TOP_W-1:0];
            st_q.irq       <= 1'b0;
            st_q.mode_prev <= '0;
            st_q.chan_prev <= '0;
            st_q.primed    <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_irq = st_q.irq;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence s_rd_freq;
        rd_fire && (i_axi.araddr == {sisf_pkg::IDX_PLL_FREQ_READBACK_TOP[5:0], 2'h0});
    endsequence

    sequence s_clear_status;
        wr_lane0 && (wr_idx == sisf_pkg::IDX_IRQ_STATUS_MID_BYTE);
    endsequence

    AST_MODE_CHANGE_SETS: assert property (
        st_q.primed && (i_op_mode != st_q.mode_prev) |=> status[sisf_pkg::BIT_MODE_CHG])
        else $error("mode change not latched");

    AST_REF_FAIL_SETS: assert property (
        ref_fail && !i_freerun_holdover |=> status[sisf_pkg::BIT_REF_FAIL])
        else $error("reference failure not latched");

    AST_REF_FAIL_GATED: assert property (
        i_freerun_holdover && !status[sisf_pkg::BIT_REF_FAIL] && !pend[sisf_pkg::BIT_REF_FAIL]
        |=> !pend[sisf_pkg::BIT_REF_FAIL])
        else $error("reference failure flagged in free-run or holdover");

    AST_CHAN_CHANGE_SETS: assert property (
        st_q.primed && (i_chan_valid != $past(i_chan_valid))
        |=> ((status[sisf_pkg::CHAN_N-1:0] & $past(i_chan_valid ^ st_q.chan_prev))
             == $past(i_chan_valid ^ st_q.chan_prev)))
        else $error("channel validity change not latched");

    AST_W1C_CLEARS: assert property (
        s_clear_status ##0 (evt == '0) ##0 (i_axi.wdata[sisf_pkg::STAT_W-1:0] != '0)
        |=> ((status & $past(i_axi.wdata[sisf_pkg::STAT_W-1:0])) == '0))
        else $error("write one did not clear status");

    AST_RESET_VALUE: assert property (disable iff (1'b0)
        !i_rst_b |=> (status == sisf_pkg::STATUS_RST))
        else $error("status reset value wrong");

    AST_FREQ_READ: assert property (
        s_rd_freq |=> st_q.rvalid && (st_q.rdata[31:sisf_pkg::FREQ_TOP_W] == '0)
                      && (st_q.rdata[sisf_pkg::FREQ_TOP_W-1:0] == $past(st_q.freq_top)))
        else $error("frequency readback wrong");

    AST_PATH_SELECT: assert property (
        ##1 (st_q.freq_top == ($past(st_q.src_sel) ?
            $past(i_auxiliary_dpll_path_freq[sisf_pkg::FREQ_TOP_LSB +: sisf_pkg::FREQ_TOP_W]) :
            $past(i_main_dpll_path_freq[sisf_pkg::FREQ_TOP_LSB +: sisf_pkg::FREQ_TOP_W]))))
        else $error("path select reports wrong path");

    AST_ZERO_KEEPS: assert property (
        s_clear_status ##0 status[sisf_pkg::BIT_MODE_CHG]
        ##0 !i_axi.wdata[sisf_pkg::BIT_MODE_CHG] |=> status[sisf_pkg::BIT_MODE_CHG])
        else $error("zero write cleared a status bit");

    // -------------------------------------------------------------------
    // bus and interrupt checks
    // -------------------------------------------------------------------
    sequence s_b_waits;
        st_q.bvalid && !i_axi.bready;
    endsequence

    sequence s_r_waits;
        st_q.rvalid && !i_axi.rready;
    endsequence

    sequence s_rd_pend;
        rd_fire && is_mapped(i_axi.araddr) && (rd_idx == sisf_pkg::IDX_IRQ_PEND);
    endsequence

    AST_IRQ_RISES: assert property (
        (|(pend & st_q.mask)) |=> o_irq)
        else $error("unmasked pending flag did not raise irq");

    AST_IRQ_FALLS: assert property (
        (!(|(pend & st_q.mask))) |=> !o_irq)
        else $error("irq high without unmasked pending flag");

    AST_WRITE_ANSWERED: assert property (
        wr_fire |=> st_q.bvalid)
        else $error("write taken without response");

    AST_READ_ANSWERED: assert property (
        rd_fire |=> st_q.rvalid)
        else $error("read taken without response");

    AST_B_STANDS: assert property (
        s_b_waits |=> st_q.bvalid && $stable(st_q.bresp))
        else $error("write response dropped before bready");

    AST_R_STANDS: assert property (
        s_r_waits
        |=> st_q.rvalid && $stable(st_q.rdata) && $stable(st_q.rresp))
        else $error("read response dropped before rready");

    AST_UNMAPPED_ERR: assert property (
        wr_fire && !is_mapped(i_axi.awaddr)
        |=> (st_q.bresp == sisf_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");

    AST_PEND_READ_CLEARS: assert property (
        s_rd_pend ##0 (evt == '0) |=> (pend == '0))
        else $error("pending flags not cleared by read");

    AST_STATUS_HOLDS: assert property (
        (evt == '0) && (status_clr == '0) |=> $stable(status))
        else $error("status changed without event or clear");

    AST_REF_FAIL_NO_SET: assert property (
        i_freerun_holdover && !status[sisf_pkg::BIT_REF_FAIL] |=> !status[sisf_pkg::BIT_REF_FAIL])
        else $error("reference failure set in free-run or holdover");

endmodule : sisf_top

//--- rtl/sisf_pkg.sv
package sisf_pkg;

    // -------------------------------------------------------------------
    // register map (word index, byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_IRQ_STATUS_MID_BYTE   = 8'h06;
    localparam logic [7:0] IDX_PLL_FREQ_READBACK_TOP = 8'h07;
    localparam logic [7:0] IDX_SRC_CFG               = 8'h08;
    localparam logic [7:0] IDX_IRQ_MASK              = 8'h09;
    localparam logic [7:0] IDX_IRQ_PEND              = 8'h0A;

    // -------------------------------------------------------------------
    // reset values and field layout
    // -------------------------------------------------------------------
    localparam int         STAT_W          = 8;
    localparam logic [7:0] STATUS_RST      = 8'h3F;
    localparam logic [7:0] FREQ_TOP_RST    = 8'h00;
    localparam logic [7:0] MASK_RST        = 8'h00;
    localparam logic [7:0] PEND_RST        = 8'h00;
    localparam logic       SRC_SEL_RST     = 1'h0;
    localparam int         BIT_MODE_CHG    = 7;
    localparam int         BIT_REF_FAIL    = 6;
    localparam int         CHAN_N          = 6;
    localparam int         OPMODE_W        = 3;
    localparam int         FREQ_W          = 19;
    localparam int         FREQ_TOP_LSB    = 16;
    localparam int         FREQ_TOP_W      = 3;
    localparam int         SEL_BIT         = 0;
    localparam logic [1:0] MISS_LIMIT      = 2'h2;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    // -------------------------------------------------------------------
    // bus carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } sisf_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sisf_axi_rsp_t;

    // -------------------------------------------------------------------
    // module state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [STAT_W-1:0] flags;
    } sisf_flag_state_t;

    typedef struct packed {
        logic [1:0] miss_cnt;
        logic       fail;
    } sisf_miss_state_t;

    typedef struct packed {
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic                  src_sel;
        logic [STAT_W-1:0]     mask;
        logic [FREQ_TOP_W-1:0] freq_top;
        logic                  irq;
        logic [OPMODE_W-1:0]   mode_prev;
        logic [CHAN_N-1:0]     chan_prev;
        logic                  primed;
    } sisf_state_t;

endpackage : sisf_pkg

//--- rtl/sisf_flag_bank.sv
// sticky flags: set pulses win over clear pulses
module sisf_flag_bank #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_b,
    // events
    input  wire logic [sisf_pkg::STAT_W-1:0] i_set,
    input  wire logic [sisf_pkg::STAT_W-1:0] i_clr,
    // flags
    output logic      [sisf_pkg::STAT_W-1:0] o_flags
);

    sisf_pkg::sisf_flag_state_t st_q;
    sisf_pkg::sisf_flag_state_t st_d;

    always_comb
    begin
        st_d       = st_q;
        st_d.flags = (st_q.flags & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_q.flags <= RST_VAL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_flags = st_q.flags;

    AST_FLAG_SET_WINS: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        |i_set |=> ((o_flags & $past(i_set)) == $past(i_set)))
        else $error("set event lost against clear");

endmodule : sisf_flag_bank

//--- rtl/sisf_miss_detect.sv
// counts consecutive missing reference cycles of the main path
module sisf_miss_detect (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // reference monitor
    input  wire logic i_cycle_tick,
    input  wire logic i_cycle_seen,
    input  wire logic i_freerun_holdover,
    // result
    output logic      o_fail
);

    sisf_pkg::sisf_miss_state_t st_q;
    sisf_pkg::sisf_miss_state_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.fail = 1'b0;
        if (i_freerun_holdover)
        begin
            st_d.miss_cnt = 2'h0;
        end
        else if (i_cycle_tick)
        begin
            if (i_cycle_seen)
            begin
                st_d.miss_cnt = 2'h0;
            end
            else if (st_q.miss_cnt < sisf_pkg::MISS_LIMIT)
            begin
                st_d.miss_cnt = st_q.miss_cnt + 2'h1;
                st_d.fail     = (st_q.miss_cnt == sisf_pkg::MISS_LIMIT - 2'h1);
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_q.miss_cnt <= 2'h0;
            st_q.fail     <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_fail = st_q.fail;

    sequence s_second_miss;
        i_cycle_tick && !i_cycle_seen && !i_freerun_holdover && (st_q.miss_cnt == 2'h1);
    endsequence

    AST_TWO_MISSES_FAIL: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_second_miss |=> o_fail)
        else $error("second missing cycle did not raise failure");

    AST_NO_FAIL_GATED: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_freerun_holdover |=> !o_fail)
        else $error("failure raised in free-run or holdover");

endmodule : sisf_miss_detect

//--- dv/sisf_test.sv
module sisf_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // clock, reset and stimulus
    // ------------------------------------------------------------------
    logic                                i_clock     = 1'b0;
    logic                                i_rst_b     = 1'b0;
    sisf_pkg::sisf_axi_req_t             axi_req     = '0;
    sisf_pkg::sisf_axi_rsp_t             axi_rsp;
    logic [sisf_pkg::OPMODE_W-1:0]       op_mode     = 3'h0;
    logic                                free_hold   = 1'b0;
    logic                                ref_tick    = 1'b0;
    logic                                ref_seen    = 1'b0;
    logic [sisf_pkg::CHAN_N-1:0]         chan_valid  = 6'h00;
    logic [sisf_pkg::FREQ_W-1:0]         main_freq   = 19'h00000;
    logic [sisf_pkg::FREQ_W-1:0]         aux_freq    = 19'h00000;
    logic                                irq;
    int                                  num_errors  = 0;
    int                                  checks      = 0;

    always #50 i_clock = ~i_clock;

    sisf_top dut (
        .i_clock                    (i_clock),
        .i_rst_b                    (i_rst_b),
        .i_axi                      (axi_req),
        .o_axi                      (axi_rsp),
        .i_op_mode                  (op_mode),
        .i_freerun_holdover         (free_hold),
        .i_ref_cycle_tick           (ref_tick),
        .i_ref_cycle_seen           (ref_seen),
        .i_chan_valid               (chan_valid),
        .i_main_dpll_path_freq      (main_freq),
        .i_auxiliary_dpll_path_freq (aux_freq),
        .o_irq                      (irq)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang;
        num_errors++;
        $display("MISMATCH at %0t: bus handshake never completed", $time);
        complete_run();
    endtask : hang

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cyc

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hF;
        axi_req.bready  <= 1'b1;
        do
        begin
            @(posedge i_clock);
            n++;
        end while (!(axi_rsp.awready === 1'b1 && axi_rsp.wready === 1'b1) && n < 50);
        if (n >= 50)
            hang();
        axi_req.awvalid <= 1'b0;
        axi_req.wvalid  <= 1'b0;
        do
        begin
            @(posedge i_clock);
            n++;
        end while (axi_rsp.bvalid !== 1'b1 && n < 100);
        if (n >= 100)
            hang();
        chk({30'h0, axi_rsp.bresp}, {30'h0, er}, "write response");
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        axi_req.rready  <= 1'b1;
        do
        begin
            @(posedge i_clock);
            n++;
        end while (axi_rsp.arready !== 1'b1 && n < 50);
        if (n >= 50)
            hang();
        axi_req.arvalid <= 1'b0;
        do
        begin
            @(posedge i_clock);
            n++;
        end while (axi_rsp.rvalid !== 1'b1 && n < 100);
        if (n >= 100)
            hang();
        chk(axi_rsp.rdata, ed, "read data");
        chk({30'h0, axi_rsp.rresp}, {30'h0, er}, "read response");
    endtask : axi_rd

    task automatic pulse_ref(input logic seen);
        ref_tick <= 1'b1;
        ref_seen <= seen;
        @(posedge i_clock);
        ref_tick <= 1'b0;
        ref_seen <= 1'b0;
        cyc(2);
    endtask : pulse_ref

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset;
        axi_rd(8'h18, 32'h0000003F, sisf_pkg::RESP_OKAY);
        axi_rd(8'h1C, 32'h00000000, sisf_pkg::RESP_OKAY);
        axi_rd(8'h40, 32'h00000000, sisf_pkg::RESP_SLVERR);
        axi_wr(8'h40, 32'h000000FF, sisf_pkg::RESP_SLVERR);
        chk({31'h0, irq}, 32'h0, "irq after reset");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_w1c;
        axi_wr(8'h18, 32'h00000000, sisf_pkg::RESP_OKAY);
        axi_rd(8'h18, 32'h0000003F, sisf_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'h00000005, sisf_pkg::RESP_OKAY);
        axi_rd(8'h18, 32'h0000003A, sisf_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'h0000003A, sisf_pkg::RESP_OKAY);
        axi_rd(8'h18, 32'h00000000, sisf_pkg::RESP_OKAY);
        $display("test_w1c done");
    endtask : test_w1c

    task automatic test_events;
        op_mode    <= 3'h3;
        chan_valid <= 6'h21;
        cyc(4);
        axi_rd(8'h18, 32'h000000A1, sisf_pkg::RESP_OKAY);
        chk({31'h0, irq}, 32'h0, "irq while masked");
        axi_wr(8'h18, 32'h000000FF, sisf_pkg::RESP_OKAY);
        chan_valid <= 6'h0C;
        cyc(4);
        axi_rd(8'h18, 32'h0000002D, sisf_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'h000000FF, sisf_pkg::RESP_OKAY);
        axi_rd(8'h18, 32'h00000000, sisf_pkg::RESP_OKAY);
        $display("test_events done");
    endtask : test_events

    task automatic test_ref;
        free_hold <= 1'b1;
        pulse_ref(1'b0);
        pulse_ref(1'b0);
        pulse_ref(1'b0);
        cyc(3);
        axi_rd(8'h18, 32'h00000000, sisf_pkg::RESP_OKAY);
        free_hold <= 1'b0;
        pulse_ref(1'b1);
        pulse_ref(1'b0);
        cyc(3);
        axi_rd(8'h18, 32'h00000000, sisf_pkg::RESP_OKAY);
        pulse_ref(1'b0);
        cyc(3);
        axi_rd(8'h18, 32'h00000040, sisf_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'h00000040, sisf_pkg::RESP_OKAY);
        pulse_ref(1'b1);
        $display("test_ref done");
    endtask : test_ref

    task automatic test_freq;
        main_freq <= 19'h51234;
        aux_freq  <= 19'h2ABCD;
        cyc(3);
        axi_rd(8'h1C, 32'h00000005, sisf_pkg::RESP_OKAY);
        axi_wr(8'h20, 32'h00000001, sisf_pkg::RESP_OKAY);
        cyc(3);
        axi_rd(8'h1C, 32'h00000002, sisf_pkg::RESP_OKAY);
        axi_wr(8'h1C, 32'h000000FF, sisf_pkg::RESP_OKAY);
        axi_rd(8'h1C, 32'h00000002, sisf_pkg::RESP_OKAY);
        aux_freq  <= 19'h7FFFF;
        cyc(3);
        axi_rd(8'h1C, 32'h00000007, sisf_pkg::RESP_OKAY);
        axi_wr(8'h20, 32'h00000000, sisf_pkg::RESP_OKAY);
        cyc(3);
        axi_rd(8'h1C, 32'h00000005, sisf_pkg::RESP_OKAY);
        $display("test_freq done");
    endtask : test_freq

    task automatic test_irq;
        axi_rd(8'h29, 32'h00000000, sisf_pkg::RESP_SLVERR);
        axi_rd(8'h28, 32'h000000ED, sisf_pkg::RESP_OKAY);
        axi_wr(8'h24, 32'h00000080, sisf_pkg::RESP_OKAY);
        chan_valid <= 6'h0D;
        cyc(4);
        chk({31'h0, irq}, 32'h0, "irq with event masked");
        op_mode <= 3'h5;
        cyc(4);
        chk({31'h0, irq}, 32'h1, "irq raised");
        axi_rd(8'h28, 32'h00000081, sisf_pkg::RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h0, "irq after pending read");
        axi_rd(8'h18, 32'h00000081, sisf_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'h00000081, sisf_pkg::RESP_OKAY);
        axi_wr(8'h24, 32'h00000000, sisf_pkg::RESP_OKAY);
        $display("test_irq done");
    endtask : test_irq

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cyc(6);
        i_rst_b <= 1'b1;
        cyc(4);
        test_reset();
        test_w1c();
        test_events();
        test_ref();
        test_freq();
        test_irq();
        complete_run();
    end

endmodule : sisf_test
